// ===== rtl/pwic_pkg.sv
package pwic_pkg;
   // ****************************************************************
   // io addresses
   // ****************************************************************
   localparam logic [5:0] PWIC_ADDR_EDGE_SEL = 6'h0c; // interrupt edge select, write only
   localparam logic [5:0] PWIC_ADDR_WAKE_EN = 6'h0d; // wake enable, write only
   localparam logic [5:0] PWIC_ADDR_PORT_DATA = 6'h10; // port data
   localparam logic [5:0] PWIC_ADDR_PORT_DIR = 6'h11; // port direction
   localparam logic [5:0] PWIC_ADDR_PULL_UP = 6'h12; // pull-up enable
   localparam logic [5:0] PWIC_ADDR_MISC = 6'h3b; // wake, low voltage reset, watchdog control

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] PWIC_RST_EDGE_SEL = 8'h00;
   localparam logic [7:0] PWIC_RST_WAKE_EN = 8'hf9; // bits 7-3 and bit 0 set
   localparam logic [7:0] PWIC_RST_PORT = 8'h00;
   localparam logic [7:0] PWIC_RST_MISC = 8'h00;

   // ****************************************************************
   // field positions and masks
   // ****************************************************************
   localparam int PWIC_TMR_EDGE_BIT = 4; // timer edge select
   localparam int PWIC_FAST_WAKE_BIT = 5; // fast wake
   localparam int PWIC_LVR_DIS_BIT = 2; // low voltage reset disable
   localparam int PWIC_PIN_FIVE = 5; // pin without pull-up
   localparam logic [7:0] PWIC_EDGE_SEL_MASK = 8'h13; // writable edge select bits
   localparam logic [7:0] PWIC_WAKE_EN_MASK = 8'hf9; // writable wake enable bits
   localparam logic [7:0] PWIC_MISC_MASK = 8'h27; // writable misc bits
   localparam logic [7:0] PWIC_PULL_MASK = 8'hdf; // pins that own a pull-up

   // external pin edge modes
   localparam logic [1:0] PWIC_EDGE_BOTH = 2'b00;
   localparam logic [1:0] PWIC_EDGE_RISE = 2'b01;
   localparam logic [1:0] PWIC_EDGE_FALL = 2'b10;

   // ****************************************************************
   // wake-up delays and watchdog periods
   // ****************************************************************
   localparam int PWIC_WAKE_SLOW_CLKS = 1024; // slow oscillator clocks
   localparam int PWIC_WAKE_FAST_CLKS = 128; // system clocks
   localparam logic [14:0] PWIC_WDT_P0 = 15'd2048;
   localparam logic [14:0] PWIC_WDT_P1 = 15'd4096;
   localparam logic [14:0] PWIC_WDT_P2 = 15'd16384;
   localparam logic [14:0] PWIC_WDT_P3 = 15'd256;
endpackage : pwic_pkg

// ===== rtl/pwic_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
// level to edge event carrier between top and edge detector
interface pwic_edge_if;
   logic level; // input level, may be asynchronous
   logic rise; // one-cycle rising event
   logic fall; // one-cycle falling event
   modport src (output level, input rise, input fall);
   modport det (input level, output rise, output fall);
endinterface : pwic_edge_if
`default_nettype wire

// ===== rtl/pwic_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser and edge detector; one event per edge
module pwic_edge_det
   #(parameter bit SYNC = 1'b1)
   (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // event carrier
   pwic_edge_if.det edge_io
   );
   logic s1_reg, s1_next; // first sync stage, read only by s2
   logic s2_reg, s2_next; // second sync stage
   logic prev_reg, prev_next; // previous sampled level
   logic [2:0] vld_reg, vld_next; // which stages hold a real sample since reset

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      s1_next = edge_io.level;
      s2_next = SYNC ? s1_reg : edge_io.level;
      prev_next = s2_reg;
      vld_next = {vld_reg[1:0], 1'b1};
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         prev_reg <= 1'b0;
         vld_reg <= 3'b000;
      end
      else
      begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         prev_reg <= prev_next;
         vld_reg <= vld_next;
      end
   end

   // single-cycle events from the stable stages only
   // events wait until prev holds a real sample: a pin already high at reset release
   // would otherwise look like a rising edge; events are masked for the first three cycles after release
   assign edge_io.rise = vld_reg[2] & s2_reg & ~prev_reg;
   assign edge_io.fall = vld_reg[2] & ~s2_reg & prev_reg;
endmodule : pwic_edge_det
`default_nettype wire

// ===== rtl/pwic_bank.sv
`timescale 1ns/1ps
`default_nettype none
module pwic_bank
   import pwic_pkg::*;
   (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // cpu io access
   input wire logic [5:0] i_io_addr,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [7:0] i_io_wdata,
   output logic [7:0] o_io_rdata,
   // port pins
   input wire logic [7:0] i_port_pins,
   output logic [7:0] o_port_out,
   output logic [7:0] o_port_oe,
   output logic [7:0] o_port_pull_up,
   // timer and interrupt core
   input wire logic i_timer_sel_bit,
   input wire logic i_ext_irq_enable,
   input wire logic i_ext_irq_clear,
   input wire logic i_timer_irq_clear,
   output logic o_ext_irq_flag,
   output logic o_ext_irq_req,
   output logic o_timer_irq_flag,
   // sleep and wake
   input wire logic i_sleep,
   input wire logic i_slow_osc_tick,
   input wire logic i_fast_osc_sel,
   output logic o_wake_event,
   output logic o_wake_done,
   // misc controls
   output logic o_lvr_enable,
   output logic [14:0] o_wdt_period
   );
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0] edge_sel_reg, edge_sel_next; // interrupt edge select
   logic [7:0] wake_en_reg, wake_en_next; // wake enables
   logic [7:0] port_data_reg, port_data_next; // port data
   logic [7:0] port_dir_reg, port_dir_next; // port direction
   logic [7:0] pull_reg, pull_next; // pull-up enables
   logic [7:0] misc_reg, misc_next; // wake, lvr, watchdog
   logic [7:0] rdata_reg, rdata_next; // read data
   logic ext_flag_reg, ext_flag_next; // external pin request
   logic tmr_flag_reg, tmr_flag_next; // timer request
   logic ext_req_reg, ext_req_next; // gated request to cpu
   logic wake_ev_reg, wake_ev_next; // one-cycle wake event
   logic done_reg, done_next; // wake delay finished pulse
   logic [10:0] wcnt_reg, wcnt_next; // wake delay counter
   logic [7:0] pins_prev_reg, pins_prev_next; // previous synced upper pins
   logic [7:0] out_reg, oe_reg, pu_reg; // registered pin controls
   logic lvr_reg;
   logic [14:0] wdt_reg;

   typedef enum logic [1:0] {PWIC_RUN, PWIC_SLEEP, PWIC_WAIT} pwic_state_e;
   pwic_state_e st_reg, st_next;

   // ****************************************************************
   // edge detectors
   // ****************************************************************
   pwic_edge_if ext_if ();
   pwic_edge_if tmr_if ();
   assign ext_if.level = i_port_pins[0];
   assign tmr_if.level = i_timer_sel_bit;

   // pin is asynchronous to us, so two stages
   pwic_edge_det #(.SYNC(1'b1)) u_ext_det (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .edge_io(ext_if));
   // timer bit already lives on the system clock
   pwic_edge_det #(.SYNC(1'b0)) u_tmr_det (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .edge_io(tmr_if));

   // upper pins synchroniser for wake toggles
   logic [7:0] up_s1_reg, up_s2_reg;

   // watchdog period decode
   function automatic logic [14:0] wdt_decode(input logic [1:0] sel);
      case (sel)
         2'b00: wdt_decode = PWIC_WDT_P0;
         2'b01: wdt_decode = PWIC_WDT_P1;
         2'b10: wdt_decode = PWIC_WDT_P2;
         default: wdt_decode = PWIC_WDT_P3;
      endcase
   endfunction

   logic ext_hit, tmr_hit, up_toggle, wake_src;

   // ****************************************************************
   // register writes and events
   // ****************************************************************
   always_comb
   begin
      edge_sel_next = edge_sel_reg;
      wake_en_next = wake_en_reg;
      port_data_next = port_data_reg;
      port_dir_next = port_dir_reg;
      pull_next = pull_reg;
      misc_next = misc_reg;
      // reserved bits masked off; software is expected to write zero there
      if (i_io_wr)
      begin
         case (i_io_addr)
            PWIC_ADDR_EDGE_SEL: edge_sel_next = i_io_wdata & PWIC_EDGE_SEL_MASK;
            PWIC_ADDR_WAKE_EN: wake_en_next = i_io_wdata & PWIC_WAKE_EN_MASK;
            PWIC_ADDR_PORT_DATA: port_data_next = i_io_wdata;
            PWIC_ADDR_PORT_DIR: port_dir_next = i_io_wdata;
            PWIC_ADDR_PULL_UP: pull_next = i_io_wdata;
            PWIC_ADDR_MISC: misc_next = i_io_wdata & PWIC_MISC_MASK;
            default: ; // unmapped write ignored
         endcase
      end
      // external pin trigger mode; reserved code 11 never triggers
      case (edge_sel_reg[1:0])
         PWIC_EDGE_BOTH: ext_hit = ext_if.rise | ext_if.fall;
         PWIC_EDGE_RISE: ext_hit = ext_if.rise;
         PWIC_EDGE_FALL: ext_hit = ext_if.fall;
         default: ext_hit = 1'b0;
      endcase
      ext_hit = ext_hit & wake_en_reg[0];
      tmr_hit = edge_sel_reg[PWIC_TMR_EDGE_BIT] ? tmr_if.fall : tmr_if.rise;
      // set wins over a clear in the same cycle
      ext_flag_next = ext_hit | (ext_flag_reg & ~i_ext_irq_clear);
      tmr_flag_next = tmr_hit | (tmr_flag_reg & ~i_timer_irq_clear);
      ext_req_next = ext_flag_next & i_ext_irq_enable;
      // upper pin toggles gated per bit
      up_toggle = |((up_s2_reg ^ pins_prev_reg) & wake_en_reg & 8'hf8);
      pins_prev_next = up_s2_reg;
      wake_src = up_toggle | ext_hit;
      // write-only registers read back zero
      case (i_io_addr)
         PWIC_ADDR_PORT_DATA: rdata_next = port_data_reg;
         PWIC_ADDR_PORT_DIR: rdata_next = port_dir_reg;
         PWIC_ADDR_PULL_UP: rdata_next = pull_reg;
         default: rdata_next = 8'h00;
      endcase
      if (!i_io_rd)
      begin
         rdata_next = rdata_reg;
      end
   end

   // ****************************************************************
   // wake sequencer
   // ****************************************************************
   always_comb
   begin
      st_next = st_reg;
      wcnt_next = wcnt_reg;
      wake_ev_next = 1'b0;
      done_next = 1'b0;
      case (st_reg)
         PWIC_RUN:
         begin
            if (i_sleep)
            begin
               st_next = PWIC_SLEEP;
            end
         end
         PWIC_SLEEP:
         begin
            if (wake_src)
            begin
               wake_ev_next = 1'b1;
               wcnt_next = '0;
               st_next = PWIC_WAIT;
            end
         end
         PWIC_WAIT:
         begin
            // fast path counts system clocks, only with fast oscillator
            if (misc_reg[PWIC_FAST_WAKE_BIT] && i_fast_osc_sel)
            begin
               wcnt_next = wcnt_reg + 11'd1;
               if (wcnt_reg == 11'(PWIC_WAKE_FAST_CLKS - 1))
               begin
                  done_next = 1'b1;
                  st_next = PWIC_RUN;
               end
            end
            // normal path counts slow oscillator ticks
            else if (i_slow_osc_tick)
            begin
               wcnt_next = wcnt_reg + 11'd1;
               if (wcnt_reg == 11'(PWIC_WAKE_SLOW_CLKS - 1))
               begin
                  done_next = 1'b1;
                  st_next = PWIC_RUN;
               end
            end
         end
         default: st_next = PWIC_RUN;
      endcase
   end

   // ****************************************************************
   // state registers
   // ****************************************************************
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         edge_sel_reg <= PWIC_RST_EDGE_SEL;
         wake_en_reg <= PWIC_RST_WAKE_EN;
         port_data_reg <= PWIC_RST_PORT;
         port_dir_reg <= PWIC_RST_PORT;
         pull_reg <= PWIC_RST_PORT;
         misc_reg <= PWIC_RST_MISC;
         rdata_reg <= 8'h00;
         ext_flag_reg <= 1'b0;
         tmr_flag_reg <= 1'b0;
         ext_req_reg <= 1'b0;
         wake_ev_reg <= 1'b0;
         done_reg <= 1'b0;
         wcnt_reg <= '0;
         pins_prev_reg <= 8'h00;
         up_s1_reg <= 8'h00;
         up_s2_reg <= 8'h00;
         out_reg <= 8'h00;
         oe_reg <= 8'h00;
         pu_reg <= 8'h00;
         lvr_reg <= 1'b1;
         wdt_reg <= PWIC_WDT_P0;
         st_reg <= PWIC_RUN;
      end
      else
      begin
         edge_sel_reg <= edge_sel_next;
         wake_en_reg <= wake_en_next;
         port_data_reg <= port_data_next;
         port_dir_reg <= port_dir_next;
         pull_reg <= pull_next;
         misc_reg <= misc_next;
         rdata_reg <= rdata_next;
         ext_flag_reg <= ext_flag_next;
         tmr_flag_reg <= tmr_flag_next;
         ext_req_reg <= ext_req_next;
         wake_ev_reg <= wake_ev_next;
         done_reg <= done_next;
         wcnt_reg <= wcnt_next;
         pins_prev_reg <= pins_prev_next;
         up_s1_reg <= i_port_pins;
         up_s2_reg <= up_s1_reg;
         out_reg <= port_data_next;
         oe_reg <= port_dir_next;
         pu_reg <= pull_next & PWIC_PULL_MASK; // pin five has no pull-up
         lvr_reg <= ~misc_next[PWIC_LVR_DIS_BIT];
         wdt_reg <= wdt_decode(misc_next[1:0]);
         st_reg <= st_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign o_io_rdata = rdata_reg;
   assign o_port_out = out_reg;
   assign o_port_oe = oe_reg;
   assign o_port_pull_up = pu_reg;
   assign o_ext_irq_flag = ext_flag_reg;
   assign o_ext_irq_req = ext_req_reg;
   assign o_timer_irq_flag = tmr_flag_reg;
   assign o_wake_event = wake_ev_reg;
   assign o_wake_done = done_reg;
   assign o_lvr_enable = lvr_reg;
   assign o_wdt_period = wdt_reg;
endmodule : pwic_bank
`default_nettype wire

// ===== dv/pwic_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************
// checker on the bank top ports
// ******************************
module pwic_bank_monitor
   import pwic_pkg::*;
   (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // cpu io access
   input wire logic [5:0] i_io_addr,
   input wire logic i_io_wr,
   input wire logic [7:0] i_io_wdata,
   // interrupt and wake inputs
   input wire logic i_timer_sel_bit,
   input wire logic i_ext_irq_enable,
   input wire logic i_ext_irq_clear,
   input wire logic i_timer_irq_clear,
   input wire logic i_fast_osc_sel,
   // watched outputs
   input wire logic [7:0] o_port_out,
   input wire logic [7:0] o_port_oe,
   input wire logic [7:0] o_port_pull_up,
   input wire logic o_ext_irq_flag,
   input wire logic o_ext_irq_req,
   input wire logic o_timer_irq_flag,
   input wire logic o_wake_event,
   input wire logic o_wake_done,
   input wire logic o_lvr_enable,
   input wire logic [14:0] o_wdt_period
   );
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);
   // shadow of write-only bits, they cannot be read back: mode, wake0, timer fall, fast
   logic [4:0] cfg_reg;
   logic [4:0] cfg_next;
   logic wr_edge; // write to edge select
   logic wr_misc; // write to misc
   assign wr_edge = i_io_wr && i_io_addr == PWIC_ADDR_EDGE_SEL;
   assign wr_misc = i_io_wr && i_io_addr == PWIC_ADDR_MISC;
   // shadow next value
   always_comb
   begin
      cfg_next = cfg_reg;
      if (wr_misc) cfg_next[0] = i_io_wdata[PWIC_FAST_WAKE_BIT];
      if (wr_edge) cfg_next[1] = i_io_wdata[PWIC_TMR_EDGE_BIT];
      if (wr_edge) cfg_next[4:3] = i_io_wdata[1:0];
      if (i_io_wr && i_io_addr == PWIC_ADDR_WAKE_EN) cfg_next[2] = i_io_wdata[0];
   end
   // shadow register
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n) cfg_reg <= 5'b0_0100;
      else cfg_reg <= cfg_next;
   end
   // watchdog period per select code
   function automatic logic [14:0] f_wdt(input logic [1:0] c);
      return (c == 2'b00) ? PWIC_WDT_P0 : (c == 2'b01) ? PWIC_WDT_P1 : (c == 2'b10) ? PWIC_WDT_P2 : PWIC_WDT_P3;
   endfunction
   sequence s_fast_start;
      o_wake_event && cfg_reg[0] && i_fast_osc_sel;
   endsequence
   sequence s_ext_blocked;
      (!cfg_reg[2] || cfg_reg[4:3] == 2'b11) [*4] ##1 !o_ext_irq_flag;
   endsequence
   property p_port_data;
      i_io_wr && i_io_addr == PWIC_ADDR_PORT_DATA |=> o_port_out == $past(i_io_wdata);
   endproperty
   a_port_data: assert property (p_port_data) else $error("port data not written");
   property p_port_dir;
      i_io_wr && i_io_addr == PWIC_ADDR_PORT_DIR |=> o_port_oe == $past(i_io_wdata);
   endproperty
   a_port_dir: assert property (p_port_dir) else $error("direction not written");
   property p_pull_up;
      i_io_wr && i_io_addr == PWIC_ADDR_PULL_UP |=> o_port_pull_up == ($past(i_io_wdata) & 8'hdf);
   endproperty
   a_pull_up: assert property (p_pull_up) else $error("pull-up not written");
   property p_pin_five;
      o_port_oe != 8'h00 |-> !o_port_pull_up[PWIC_PIN_FIVE] && $stable(o_port_pull_up[5]);
   endproperty
   a_pin_five: assert property (p_pin_five) else $error("pin five pull-up active");
   property p_misc_lvr;
      wr_misc |=> o_lvr_enable == !$past(i_io_wdata[PWIC_LVR_DIS_BIT]);
   endproperty
   a_misc_lvr: assert property (p_misc_lvr) else $error("low voltage reset enable wrong");
   property p_misc_wdt;
      wr_misc |=> o_wdt_period == f_wdt($past(i_io_wdata[1:0]));
   endproperty
   a_misc_wdt: assert property (p_misc_wdt) else $error("watchdog period wrong");
   property p_ext_quiet;
      s_ext_blocked |=> !o_ext_irq_flag;
   endproperty
   a_ext_quiet: assert property (p_ext_quiet) else $error("blocked pin raised a request");
   property p_timer_edge;
      $rose(i_timer_sel_bit) && !cfg_reg[1] && !i_timer_irq_clear |-> ##[1:3] o_timer_irq_flag;
   endproperty
   a_timer_edge: assert property (p_timer_edge) else $error("timer rise missed");
   property p_timer_sticky;
      o_timer_irq_flag && !i_timer_irq_clear |=> o_timer_irq_flag;
   endproperty
   a_timer_sticky: assert property (p_timer_sticky) else $error("timer flag dropped");
   property p_ext_req;
      o_ext_irq_flag && !i_ext_irq_clear |=> o_ext_irq_flag && o_ext_irq_req == $past(i_ext_irq_enable);
   endproperty
   a_ext_req: assert property (p_ext_req) else $error("pin request not gated by enable");
   property p_fast_wake;
      s_fast_start |-> ##1 !o_wake_done [*8] ##[115:125] o_wake_done;
   endproperty
   a_fast_wake: assert property (p_fast_wake) else $error("fast wake delay wrong");
endmodule // pwic_bank_monitor
bind pwic_bank pwic_bank_monitor mon (.i_sys_clk, .i_arst_n, .i_io_addr, .i_io_wr, .i_io_wdata, .i_timer_sel_bit,
   .i_ext_irq_enable, .i_ext_irq_clear, .i_timer_irq_clear, .i_fast_osc_sel, .o_port_out, .o_port_oe,
   .o_port_pull_up, .o_ext_irq_flag, .o_ext_irq_req, .o_timer_irq_flag, .o_wake_event, .o_wake_done,
   .o_lvr_enable, .o_wdt_period);
`default_nettype wire

// ===== dv/pwic_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// circuitry outside the port pins
module pwic_pin_model
   (
   // clock
   input wire logic i_sys_clk,
   // block pin controls
   input wire logic [7:0] i_port_out,
   input wire logic [7:0] i_port_oe,
   input wire logic [7:0] i_port_pull_up,
   // far side drive
   input wire logic [7:0] i_ext_val,
   input wire logic [7:0] i_ext_en,
   // resolved levels
   output logic [7:0] o_pins
   );
   logic flt_reg = 1'b0; // undriven pins wander, so a stale level never looks valid
   logic flt_next;
   assign flt_next = ~flt_reg;
   always_ff @(posedge i_sys_clk) flt_reg <= flt_next;
   // block output wins, then far side, then pull-up
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (i_port_oe[i]) o_pins[i] = i_port_out[i];
         else if (i_ext_en[i]) o_pins[i] = i_ext_val[i];
         else if (i_port_pull_up[i]) o_pins[i] = 1'b1;
         else o_pins[i] = flt_reg;
      end
   end
endmodule // pwic_pin_model
`default_nettype wire

// ===== dv/tb_port_wake_irq_control_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tb_port_wake_irq_control_bank
   import pwic_pkg::*;
   ;
   logic i_sys_clk = 1'b0;
   logic i_arst_n, i_io_wr, i_io_rd, i_timer_sel_bit, i_ext_irq_enable, i_ext_irq_clear, i_timer_irq_clear;
   logic i_sleep, i_fast_osc_sel, o_ext_irq_flag, o_ext_irq_req, o_timer_irq_flag;
   logic i_slow_osc_tick = 1'b0; // driven only by the tick process below
   logic o_wake_event, o_wake_done, o_lvr_enable;
   logic [5:0] i_io_addr;
   logic [7:0] i_io_wdata, o_io_rdata, i_port_pins, o_port_out, o_port_oe, o_port_pull_up, ext_val, ext_drv;
   logic [14:0] o_wdt_period;
   logic [14:0] wdt_exp [4] = '{15'd2048, 15'd4096, 15'd16384, 15'd256};
   int mismatches = 0;
   int tests_run = 0;
   int n;
   pwic_bank dut (.i_sys_clk, .i_arst_n, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata, .i_port_pins,
      .o_port_out, .o_port_oe, .o_port_pull_up, .i_timer_sel_bit, .i_ext_irq_enable, .i_ext_irq_clear,
      .i_timer_irq_clear, .o_ext_irq_flag, .o_ext_irq_req, .o_timer_irq_flag, .i_sleep, .i_slow_osc_tick,
      .i_fast_osc_sel, .o_wake_event, .o_wake_done, .o_lvr_enable, .o_wdt_period);
   pwic_pin_model pins (.i_sys_clk, .i_port_out(o_port_out), .i_port_oe(o_port_oe),
      .i_port_pull_up(o_port_pull_up), .i_ext_val(ext_val), .i_ext_en(ext_drv), .o_pins(i_port_pins));
   // ****************
   // shared tasks
   // ****************
   always #20 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) i_slow_osc_tick <= ~i_slow_osc_tick; // slow tick every other cycle
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus_write(input logic [5:0] a, input logic [7:0] d);
      i_io_wr <= 1'b1;
      i_io_addr <= a;
      i_io_wdata <= d;
      @(posedge i_sys_clk);
      i_io_wr <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   task automatic bus_read(input logic [5:0] a, input logic [7:0] e);
      i_io_rd <= 1'b1;
      i_io_addr <= a;
      @(posedge i_sys_clk);
      i_io_rd <= 1'b0;
      @(posedge i_sys_clk);
      chk(o_io_rdata, e);
   endtask
   task automatic clear_flags(input int settle);
      i_ext_irq_clear <= 1'b1;
      i_timer_irq_clear <= 1'b1;
      @(posedge i_sys_clk);
      i_ext_irq_clear <= 1'b0;
      i_timer_irq_clear <= 1'b0;
      repeat (settle) @(posedge i_sys_clk);
   endtask
   // sleep, toggle pins, count cycles from wake event to wake done (-1 if no event)
   task automatic wake_run(input logic [7:0] mask, output int cnt);
      i_sleep <= 1'b1;
      @(posedge i_sys_clk);
      i_sleep <= 1'b0;
      ext_val <= ext_val ^ mask;
      cnt = -1;
      for (int i = 0; i < 10 && cnt < 0; i++)
      begin
         @(posedge i_sys_clk);
         if (o_wake_event === 1'b1) cnt = 0;
      end
      while (cnt >= 0 && cnt < 3000 && o_wake_done !== 1'b1)
      begin
         @(posedge i_sys_clk);
         cnt++;
      end
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_regs();
      chk({o_port_out, o_port_oe, o_port_pull_up, o_lvr_enable}, 25'h000_0001);
      chk(o_wdt_period, 15'd2048);
      bus_read(PWIC_ADDR_PORT_DIR, 8'h00);
      bus_read(PWIC_ADDR_PULL_UP, 8'h00);
      i_io_wr <= 1'b1; // back to back writes
      i_io_addr <= PWIC_ADDR_PORT_DATA;
      i_io_wdata <= 8'h5a;
      @(posedge i_sys_clk);
      i_io_addr <= PWIC_ADDR_PORT_DIR;
      i_io_wdata <= 8'ha4;
      @(posedge i_sys_clk);
      i_io_addr <= PWIC_ADDR_PULL_UP;
      i_io_wdata <= 8'hff;
      @(posedge i_sys_clk);
      i_io_wr <= 1'b0;
      @(posedge i_sys_clk);
      chk({o_port_out, o_port_oe}, 16'h5aa4);
      chk(o_port_pull_up, 8'hdf);
      bus_write(6'h13, 8'hff);
      bus_read(PWIC_ADDR_PORT_DATA, 8'h5a);
      bus_read(6'h20, 8'h00);
      bus_read(PWIC_ADDR_EDGE_SEL, 8'h00);
      bus_read(PWIC_ADDR_MISC, 8'h00);
      for (int c = 0; c < 4; c++)
      begin
         bus_write(PWIC_ADDR_MISC, 8'(c * 5 & 7));
         chk({o_lvr_enable, o_wdt_period}, {c[0] == 1'b0, wdt_exp[c]});
      end
      bus_write(PWIC_ADDR_PORT_DIR, 8'h00);
      bus_write(PWIC_ADDR_PULL_UP, 8'h00);
   endtask
   task automatic t_ext_edges();
      for (int m = 0; m < 4; m++)
      begin
         i_ext_irq_enable <= m[0];
         bus_write(PWIC_ADDR_EDGE_SEL, 8'(m));
         clear_flags(1);
         ext_val[0] <= 1'b1;
         repeat (6) @(posedge i_sys_clk);
         chk({o_ext_irq_flag, o_ext_irq_req}, {m < 2, m == 1});
         clear_flags(4);
         chk(o_ext_irq_flag, 1'b0);
         ext_val[0] <= 1'b0;
         repeat (6) @(posedge i_sys_clk);
         chk(o_ext_irq_flag, m == 0 || m == 2);
         clear_flags(1);
      end
      bus_write(PWIC_ADDR_WAKE_EN, 8'h00);
      bus_write(PWIC_ADDR_EDGE_SEL, 8'h00);
      ext_val[0] <= 1'b1;
      repeat (6) @(posedge i_sys_clk);
      chk(o_ext_irq_flag, 1'b0);
   endtask
   task automatic t_timer();
      for (int e = 0; e < 2; e++)
      begin
         bus_write(PWIC_ADDR_EDGE_SEL, e ? 8'h10 : 8'h00);
         clear_flags(1);
         i_timer_sel_bit <= 1'b1;
         repeat (4) @(posedge i_sys_clk);
         chk(o_timer_irq_flag, e == 0);
         clear_flags(1);
         i_timer_sel_bit <= 1'b0;
         repeat (4) @(posedge i_sys_clk);
         chk(o_timer_irq_flag, e == 1);
      end
   endtask
   task automatic t_wake();
      wake_run(8'h08, n);
      chk(n < 0, 1'b1);
      bus_write(PWIC_ADDR_WAKE_EN, 8'h08);
      i_fast_osc_sel <= 1'b1;
      bus_write(PWIC_ADDR_MISC, 8'h20);
      wake_run(8'h08, n);
      chk(n >= 126 && n <= 131, 1'b1);
      bus_write(PWIC_ADDR_MISC, 8'h00);
      wake_run(8'h08, n);
      chk(n >= 2044 && n <= 2054, 1'b1);
   endtask
   // reset in mid-run with pin 0 high: registers return, no false pin edge after release
   task automatic t_rst_mid();
      i_arst_n <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      chk({o_port_out, o_timer_irq_flag, o_wdt_period}, 24'h00_0800);
      i_arst_n <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      chk({o_ext_irq_flag, o_port_out}, 9'h000);
      bus_read(PWIC_ADDR_PORT_DATA, 8'h00);
   endtask
   initial
   begin
      {i_arst_n, i_io_wr, i_io_rd, i_timer_sel_bit, i_ext_irq_enable, i_ext_irq_clear, i_timer_irq_clear} = '0;
      {i_sleep, i_fast_osc_sel, i_io_addr, i_io_wdata, ext_val} = '0;
      ext_drv = 8'h09; // far side drives pins 0 and 3, the rest float
      repeat (5) @(posedge i_sys_clk);
      i_arst_n <= 1'b1;
      @(posedge i_sys_clk);
      t_regs();
      t_ext_edges();
      t_timer();
      t_wake();
      t_rst_mid();
      end_of_test();
   end
   // hang guard, well beyond the longest wake
   initial
   begin
      repeat (12000) @(posedge i_sys_clk);
      mismatches++;
      end_of_test();
   end
endmodule // tb_port_wake_irq_control_bank
`default_nettype wire
